// ---- fault_latch_pkg.sv ----
// shared constants and types for the fault interrupt mask and latch bank
package fault_latch_pkg;

  // ---------------------------------------------------------------
  // register offsets on the control port
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_THR_VAD_MASK = 8'h33;
  localparam logic [7:0] OFS_CLK_LATCH    = 8'h34;
  localparam logic [7:0] OFS_CH_SUMMARY   = 8'h35;
  localparam logic [7:0] OFS_OUT1_LATCH   = 8'h38;
  localparam logic [7:0] OFS_OUT2_LATCH   = 8'h39;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_THR_VAD_MASK = 8'h30;
  localparam logic [7:0] RST_LATCH        = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_7 = 7;
  localparam int BIT_6 = 6;
  localparam int BIT_5 = 5;
  localparam int BIT_4 = 4;
  localparam int BIT_3 = 3;
  localparam int BIT_2 = 2;
  localparam int BIT_1 = 1;
  localparam int BIT_0 = 0;
  // writable bits of each read-write register
  localparam logic [7:0] WMASK_THR_VAD = 8'hF0;
  localparam logic [7:0] WMASK_OUT1    = 8'h0C;
  localparam logic [7:0] WMASK_OUT2    = 8'h02;

  // fault detector event strobes, all on ref_clk
  typedef struct packed {
    logic       clock_error;
    logic       pll_lock;
    logic       analog_up_thr;
    logic       analog_low_thr;
    logic       vad_power_up;
    logic       vad_power_down;
    logic       in1_fault;
    logic       in2_fault;
    logic [3:0] out1_fault;     // pos short, neg short, pos vgnd, neg vgnd
    logic [3:0] out2_fault;     // same order as out1_fault
    logic       adc1_overload;
    logic       adc2_overload;
    logic       regulator_short;
  } fault_event_s;

  // control port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage

// ---- fault_interrupt_mask_latch.sv ----
// fault and event latch bank with interrupt masks and read-to-clear flags
`timescale 1ns/1ps

// Behaviour
// - mask bit 7 gates upper threshold fault
// - mask bit 6 gates lower threshold fault
// - mask bit 5 gates vad up, reset 1
// - mask bit 4 gates vad down, reset 1
// - mask at 0x33 resets 0x30, low zero
// - clock error latched in bit 7
// - pll lock latched in bit 6
// - summary bit 7: input channel 1 fault
// - summary bit 6: input channel 2 fault
// - summary bit 5: output channel 1 fault
// - summary bit 4: output 2; low reads zero
// - out1 short flags in bits 7, 6
// - out1 virtual ground flags bits 5, 4
// - out1 bit 3 masks adc1 overload
// - out1 bit 2 masks adc2 overload
// - out2 short flags in bits 7, 6
// - out2 virtual ground flags bits 5, 4
// - out2 bit 0 latches regulator short
// - clock latch at 0x34, low bits zero
module fault_interrupt_mask_latch (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rstn,
  // control port
  input  wire fault_latch_pkg::reg_req_s    req,
  output logic [7:0]                        rdata,
  // fault detectors
  input  wire fault_latch_pkg::fault_event_s evt,
  // interrupt request
  output logic                              irq
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0] thr_mask_ff,  nxt_thr_mask;
  logic [1:0] clk_lat_ff,   nxt_clk_lat;
  logic [3:0] ch_sum_ff,    nxt_ch_sum;
  logic [3:0] out1_lat_ff,  nxt_out1_lat;
  logic [3:0] out2_lat_ff,  nxt_out2_lat;
  logic [1:0] adc_mask_ff,  nxt_adc_mask;
  logic       reg_mask_ff,  nxt_reg_mask;
  logic       reg_lat_ff,   nxt_reg_lat;
  logic [7:0] rdata_ff,     nxt_rdata;
  logic       irq_ff,       nxt_irq;

  logic       rd_clk, rd_sum, rd_out1, rd_out2;
  logic       wr_thr, wr_out1, wr_out2;
  logic [3:0] thr_live;

  // address decode of the control port strobes
  assign rd_clk  = req.rd && (req.addr == fault_latch_pkg::OFS_CLK_LATCH);
  assign rd_sum  = req.rd && (req.addr == fault_latch_pkg::OFS_CH_SUMMARY);
  assign rd_out1 = req.rd && (req.addr == fault_latch_pkg::OFS_OUT1_LATCH);
  assign rd_out2 = req.rd && (req.addr == fault_latch_pkg::OFS_OUT2_LATCH);
  assign wr_thr  = req.wr && (req.addr == fault_latch_pkg::OFS_THR_VAD_MASK);
  assign wr_out1 = req.wr && (req.addr == fault_latch_pkg::OFS_OUT1_LATCH);
  assign wr_out2 = req.wr && (req.addr == fault_latch_pkg::OFS_OUT2_LATCH);

  // threshold and vad events in mask bit order 7..4
  assign thr_live = {evt.analog_up_thr, evt.analog_low_thr, evt.vad_power_up, evt.vad_power_down};

  // ---------------------------------------------------------------
  // mask registers
  // ---------------------------------------------------------------
  // reserved bits are forced to zero so a stray write cannot set them
  always_comb begin
    nxt_thr_mask = thr_mask_ff;
    nxt_adc_mask = adc_mask_ff;
    nxt_reg_mask = reg_mask_ff;
    if (wr_thr) begin
      nxt_thr_mask = req.wdata & fault_latch_pkg::WMASK_THR_VAD;
    end
    if (wr_out1) begin
      nxt_adc_mask = req.wdata[fault_latch_pkg::BIT_3:fault_latch_pkg::BIT_2];
    end
    if (wr_out2) begin
      nxt_reg_mask = req.wdata[fault_latch_pkg::BIT_1];
    end
  end

  // ---------------------------------------------------------------
  // latched flags
  // ---------------------------------------------------------------
  // a flag read in the same cycle as a new event stays set, so no event is lost
  always_comb begin
    nxt_clk_lat  = (rd_clk  ? 2'h0 : clk_lat_ff);
    nxt_ch_sum   = (rd_sum  ? 4'h0 : ch_sum_ff);
    nxt_out1_lat = (rd_out1 ? 4'h0 : out1_lat_ff);
    nxt_out2_lat = (rd_out2 ? 4'h0 : out2_lat_ff);
    nxt_reg_lat  = (rd_out2 ? 1'b0 : reg_lat_ff);
    nxt_clk_lat  = nxt_clk_lat | {evt.clock_error, evt.pll_lock};
    nxt_ch_sum   = nxt_ch_sum | {evt.in1_fault, evt.in2_fault, |evt.out1_fault, |evt.out2_fault};
    // output 1 leg and driver faults
    nxt_out1_lat = nxt_out1_lat | evt.out1_fault;
    // output 2 leg and driver faults
    nxt_out2_lat = nxt_out2_lat | evt.out2_fault;
    nxt_reg_lat  = nxt_reg_lat | evt.regulator_short;
  end

  // ---------------------------------------------------------------
  // read data and interrupt
  // ---------------------------------------------------------------
  // read data is registered: it appears one cycle after the read strobe
  always_comb begin
    nxt_rdata = rdata_ff;
    if (req.rd) begin
      case (req.addr)
        fault_latch_pkg::OFS_THR_VAD_MASK: nxt_rdata = thr_mask_ff;
        fault_latch_pkg::OFS_CLK_LATCH:    nxt_rdata = {clk_lat_ff, 6'h00};
        fault_latch_pkg::OFS_CH_SUMMARY:   nxt_rdata = {ch_sum_ff, 4'h0};
        fault_latch_pkg::OFS_OUT1_LATCH:   nxt_rdata = {out1_lat_ff, adc_mask_ff, 2'h0};
        fault_latch_pkg::OFS_OUT2_LATCH:   nxt_rdata = {out2_lat_ff, 2'h0, reg_mask_ff, reg_lat_ff};
        default:                           nxt_rdata = 8'h00;
      endcase
    end
  end

  // unmasked threshold, vad and overload events pass as live levels;
  // their latches sit in another bank, so this view can only be as long as the event
  always_comb begin
    nxt_irq = (|nxt_clk_lat) || (|nxt_ch_sum) || (|nxt_out1_lat) || (|nxt_out2_lat);
    nxt_irq = nxt_irq || (|(thr_live & ~nxt_thr_mask[fault_latch_pkg::BIT_7:fault_latch_pkg::BIT_4]));
    nxt_irq = nxt_irq || (|({evt.adc1_overload, evt.adc2_overload} & ~nxt_adc_mask));
    nxt_irq = nxt_irq || (nxt_reg_lat && !nxt_reg_mask);
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  // masks come out of reset with only the two vad bits set
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      thr_mask_ff <= fault_latch_pkg::RST_THR_VAD_MASK;
      adc_mask_ff <= 2'h0;
      reg_mask_ff <= 1'b0;
    end else begin
      thr_mask_ff <= nxt_thr_mask;
      adc_mask_ff <= nxt_adc_mask;
      reg_mask_ff <= nxt_reg_mask;
    end
  end

  // latched flags start clear, so no stale event survives a reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clk_lat_ff  <= 2'h0;
      ch_sum_ff   <= 4'h0;
      out1_lat_ff <= 4'h0;
      out2_lat_ff <= 4'h0;
      reg_lat_ff  <= 1'b0;
    end else begin
      clk_lat_ff  <= nxt_clk_lat;
      ch_sum_ff   <= nxt_ch_sum;
      out1_lat_ff <= nxt_out1_lat;
      out2_lat_ff <= nxt_out2_lat;
      reg_lat_ff  <= nxt_reg_lat;
    end
  end

  // read data register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= fault_latch_pkg::RST_LATCH;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // interrupt register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  assign rdata = rdata_ff;
  assign irq   = irq_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  a_clk_err_latch: assert property (evt.clock_error |=> clk_lat_ff[1] && irq)
    else $error("clock error not latched");
  a_pll_latch: assert property (evt.pll_lock |=> clk_lat_ff[0])
    else $error("pll lock not latched");
  a_read_clears: assert property ((rd_out1 && !(|evt.out1_fault)) |=> out1_lat_ff == 4'h0)
    else $error("output 1 latch not cleared by read");
  a_set_wins: assert property ((rd_out2 && evt.regulator_short) |=> reg_lat_ff)
    else $error("regulator short lost on read");
  a_clk_readback: assert property ((req.rd && req.addr == fault_latch_pkg::OFS_CLK_LATCH)
    |=> rdata[5:0] == 6'h00 && rdata[7:6] == $past(clk_lat_ff))
    else $error("clock latch readback wrong");
  a_mask_write: assert property (wr_thr |=> thr_mask_ff == ($past(req.wdata) & 8'hF0))
    else $error("mask write wrong");
  a_mask_low_zero: assert property (thr_mask_ff[3:0] == 4'h0)
    else $error("reserved mask bits set");
  a_mask_stable: assert property (!wr_thr |=> $stable(thr_mask_ff))
    else $error("mask changed without a write");
  a_vad_masked: assert property ((clk_lat_ff == 2'h0 && ch_sum_ff == 4'h0 && out1_lat_ff == 4'h0
    && out2_lat_ff == 4'h0 && !reg_lat_ff && thr_mask_ff[5] && !wr_thr
    && evt == fault_latch_pkg::fault_event_s'{vad_power_up: 1'b1, default: '0}) |=> !irq)
    else $error("masked vad event raised irq");
  a_thr_pass: assert property ((evt.analog_up_thr && !thr_mask_ff[7] && !wr_thr) |=> irq)
    else $error("unmasked threshold fault missed");
  a_low_thr_pass: assert property ((evt.analog_low_thr && !thr_mask_ff[6] && !wr_thr) |=> irq)
    else $error("unmasked lower threshold fault missed");
  a_vad_up_pass: assert property ((evt.vad_power_up && !thr_mask_ff[5] && !wr_thr) |=> irq)
    else $error("unmasked vad power up missed");
  a_vad_down_pass: assert property ((evt.vad_power_down && !thr_mask_ff[4] && !wr_thr) |=> irq)
    else $error("unmasked vad power down missed");
  a_adc1_pass: assert property ((evt.adc1_overload && !adc_mask_ff[1] && !wr_out1) |=> irq)
    else $error("unmasked adc 1 overload missed");
  a_adc2_pass: assert property ((evt.adc2_overload && !adc_mask_ff[0] && !wr_out1) |=> irq)
    else $error("unmasked adc 2 overload missed");
  a_sum_in1: assert property (evt.in1_fault |=> ch_sum_ff[3])
    else $error("input 1 summary not set");
  a_sum_in2: assert property (evt.in2_fault |=> ch_sum_ff[2])
    else $error("input 2 summary not set");
  a_sum_out1: assert property ((|evt.out1_fault) |=> ch_sum_ff[1])
    else $error("output 1 summary not set");
  a_sum_out2: assert property ((|evt.out2_fault) |=> ch_sum_ff[0])
    else $error("output 2 summary not set");
  a_sum_readback: assert property (rd_sum |=> rdata == {$past(ch_sum_ff), 4'h0})
    else $error("summary readback wrong");
  a_out1_short: assert property ((|evt.out1_fault[3:2])
    |=> &(out1_lat_ff[3:2] | ~$past(evt.out1_fault[3:2])))
    else $error("output 1 short not latched");
  a_out1_vgnd: assert property ((|evt.out1_fault[1:0])
    |=> &(out1_lat_ff[1:0] | ~$past(evt.out1_fault[1:0])))
    else $error("output 1 virtual ground not latched");
  a_out2_short: assert property ((|evt.out2_fault[3:2])
    |=> &(out2_lat_ff[3:2] | ~$past(evt.out2_fault[3:2])))
    else $error("output 2 short not latched");
  a_out2_vgnd: assert property ((|evt.out2_fault[1:0])
    |=> &(out2_lat_ff[1:0] | ~$past(evt.out2_fault[1:0])))
    else $error("output 2 virtual ground not latched");
  a_reg_latch: assert property (evt.regulator_short |=> reg_lat_ff)
    else $error("regulator short not latched");
  a_out1_readback: assert property (rd_out1
    |=> rdata == {$past(out1_lat_ff), $past(adc_mask_ff), 2'h0})
    else $error("output 1 readback wrong");
  a_out2_readback: assert property (rd_out2
    |=> rdata == {$past(out2_lat_ff), 2'h0, $past(reg_mask_ff), $past(reg_lat_ff)})
    else $error("output 2 readback wrong");
  a_clk_clear: assert property ((rd_clk && !evt.clock_error && !evt.pll_lock) |=> clk_lat_ff == 2'h0)
    else $error("clock latch not cleared by read");
  a_sum_clear: assert property ((rd_sum && !evt.in1_fault && !evt.in2_fault
    && !(|evt.out1_fault) && !(|evt.out2_fault)) |=> ch_sum_ff == 4'h0)
    else $error("summary not cleared by read");
  a_reg_mask: assert property ((reg_lat_ff && !reg_mask_ff && !rd_out2 && !wr_out2) |=> irq)
    else $error("unmasked regulator short missed");
  a_irq_quiet: assert property ((clk_lat_ff == 2'h0 && ch_sum_ff == 4'h0 && out1_lat_ff == 4'h0
    && out2_lat_ff == 4'h0 && !reg_lat_ff && evt == '0) |=> !irq)
    else $error("irq raised with nothing pending");

  c_read_clear: cover property (rd_clk && clk_lat_ff != 2'h0 ##1 clk_lat_ff == 2'h0);
  c_mask_write: cover property (wr_thr ##1 thr_mask_ff == 8'h00);
  c_irq_rise: cover property (!irq ##1 irq);
  c_set_on_read: cover property (rd_out2 && evt.regulator_short);

endmodule

// ---- host_model.sv ----
// host processor model that drives the control port of the fault latch bank
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic                 ref_clk,
  // control port
  output fault_latch_pkg::reg_req_s req,
  input  wire logic [7:0]           rdata
);
  // ---------------------------------------------------------------
  // one-cycle strobes launched on the falling edge
  // ---------------------------------------------------------------
  initial req = '0;

  // address and data go to their inverse once released, so a stale value never looks valid
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // mask reserved nibble always written zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    access(1'b1, a, (a == fault_latch_pkg::OFS_THR_VAD_MASK) ? (d & fault_latch_pkg::WMASK_THR_VAD) : d);
  endtask

  // data is taken on the second falling edge after the strobe is launched, where it stands until the next read
  task automatic rd(input logic [7:0] a, output logic [7:0] got);
    access(1'b0, a, 8'h00);
    @(negedge ref_clk);
    got = rdata;
  endtask
endmodule

// ---- fault_interrupt_mask_latch_tb_top.sv ----
// self-checking bench for the fault interrupt mask and latch bank
`timescale 1ns/1ps
module fault_interrupt_mask_latch_tb_top;
  logic                          ref_clk = 1'b0;
  logic                          rstn = 1'b0;
  fault_latch_pkg::reg_req_s     req;
  fault_latch_pkg::fault_event_s evt = '0;
  logic [7:0]                    rdata;
  logic                          irq;
  logic [7:0]                    got;
  int                            fail_count = 0;
  int                            comparisons = 0;

  always #5 ref_clk = ~ref_clk;

  fault_interrupt_mask_latch uut (.ref_clk(ref_clk), .rstn(rstn), .req(req), .rdata(rdata), .evt(evt), .irq(irq));
  host_model host (.ref_clk(ref_clk), .req(req), .rdata(rdata));

  // ---------------------------------------------------------------
  // shared checks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, got);
    chk($sformatf("reg %h", a), exp, got);
  endtask

  // two edges let a registered irq settle after the last input change
  task automatic irq_chk(input logic exp);
    repeat (2) @(negedge ref_clk);
    chk("irq", {7'h00, exp}, {7'h00, irq});
  endtask

  task automatic pulse(input fault_latch_pkg::fault_event_s e);
    @(negedge ref_clk);
    evt = e;
    @(negedge ref_clk);
    evt = '0;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd_chk(8'h33, 8'h30);
    rd_chk(8'h34, 8'h00);
    rd_chk(8'h35, 8'h00);
    rd_chk(8'h38, 8'h00);
    rd_chk(8'h39, 8'h00);
    rd_chk(8'h36, 8'h00);
    irq_chk(1'b0);
    host.wr(8'h33, 8'hFF);
    rd_chk(8'h33, 8'hF0);
    host.wr(8'h34, 8'hFF);
    rd_chk(8'h34, 8'h00);
    host.wr(8'h33, 8'h30);
  endtask

  task automatic t_clock();
    pulse('{clock_error: 1'b1, pll_lock: 1'b1, default: '0});
    irq_chk(1'b1);
    rd_chk(8'h34, 8'hC0);
    rd_chk(8'h34, 8'h00);
    irq_chk(1'b0);
    evt.pll_lock = 1'b1;
    rd_chk(8'h34, 8'h40);
    rd_chk(8'h34, 8'h40);
    evt.pll_lock = 1'b0;
    host.rd(8'h34, got);
    rd_chk(8'h34, 8'h00);
  endtask

  task automatic t_channels();
    pulse('{in1_fault: 1'b1, in2_fault: 1'b1, out1_fault: 4'hA, out2_fault: 4'h5, default: '0});
    rd_chk(8'h35, 8'hF0);
    rd_chk(8'h35, 8'h00);
    rd_chk(8'h38, 8'hA0);
    rd_chk(8'h39, 8'h50);
    pulse('{out1_fault: 4'h5, default: '0});
    rd_chk(8'h35, 8'h20);
    rd_chk(8'h38, 8'h50);
    pulse('{out2_fault: 4'hA, default: '0});
    rd_chk(8'h35, 8'h10);
    rd_chk(8'h39, 8'hA0);
    irq_chk(1'b0);
  endtask

  task automatic t_masks();
    host.wr(8'h38, 8'hFF);
    rd_chk(8'h38, 8'h0C);
    evt.adc1_overload = 1'b1;
    irq_chk(1'b0);
    host.wr(8'h38, 8'h04);
    irq_chk(1'b1);
    evt = '{adc2_overload: 1'b1, default: '0};
    irq_chk(1'b0);
    evt = '0;
    host.wr(8'h38, 8'h00);
    host.wr(8'h39, 8'hFF);
    rd_chk(8'h39, 8'h02);
    pulse('{regulator_short: 1'b1, default: '0});
    irq_chk(1'b0);
    rd_chk(8'h39, 8'h03);
    rd_chk(8'h39, 8'h02);
    host.wr(8'h39, 8'h00);
    pulse('{regulator_short: 1'b1, default: '0});
    irq_chk(1'b1);
    rd_chk(8'h39, 8'h01);
    irq_chk(1'b0);
  endtask

  // each of the four gated sources passes unmasked and is blocked by its own bit only
  task automatic t_thresholds();
    for (int i = 0; i < 4; i++) begin
      {evt.analog_up_thr, evt.analog_low_thr, evt.vad_power_up, evt.vad_power_down} = 4'h8 >> i;
      host.wr(8'h33, 8'h00);
      irq_chk(1'b1);
      host.wr(8'h33, 8'h80 >> i);
      irq_chk(1'b0);
    end
    evt = '0;
    host.wr(8'h33, 8'h30);
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    t_reset();
    t_clock();
    t_channels();
    t_masks();
    t_thresholds();
    report_and_stop();
  end

  // hang guard: an exhausted bound counts as a mismatch
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    report_and_stop();
  end
endmodule
